/* src/pcr_consts.svh */
// timing, index and frequency constants of the clock and reset controller
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// system clock period in picoseconds (125 MHz)
`define PCR_CLK_PERIOD_PS 8000

// least time resets stay asserted before ready is given
`define PCR_ENTRY_NS 100
`define PCR_ENTRY_CYC ((`PCR_ENTRY_NS * 1000 + `PCR_CLK_PERIOD_PS - 1) / `PCR_CLK_PERIOD_PS)

// least time from request drop to core release
`define PCR_EXIT_NS 1000
`define PCR_EXIT_CYC ((`PCR_EXIT_NS * 1000 + `PCR_CLK_PERIOD_PS - 1) / `PCR_CLK_PERIOD_PS)

// longest silence of a domain clock before it is flagged as stopped
`define PCR_MON_NS 512
`define PCR_MON_CYC ((`PCR_MON_NS * 1000) / `PCR_CLK_PERIOD_PS)

// positions in the synchroniser vector
`define PCR_IDX_COLD_REQ 0
`define PCR_IDX_WARM_REQ 1
`define PCR_IDX_ST_REQ   2
`define PCR_IDX_SB_REQ   3
`define PCR_IDX_MM_REQ   4
`define PCR_IDX_ST_CLK   5
`define PCR_IDX_SB_CLK   6
`define PCR_IDX_MM_CLK   7
`define PCR_SYNC_W       8

// core clock frequencies in MHz per generation
`define PCR_CORE_MHZ_GEN4 11'd1000
`define PCR_CORE_MHZ_GEN3 11'd500
`define PCR_CORE_MHZ_GEN2 11'd250
`define PCR_CORE_MHZ_GEN1 11'd125

// application clock frequencies in MHz per configured generation
`define PCR_APP_MHZ_GEN4 10'd500
`define PCR_APP_MHZ_GEN3 10'd250

`endif

/* src/pcr_pkg.sv */
// types shared by the clock and reset controller
package pcr_pkg;

   // link generation
   typedef enum logic [1:0] {
      PCR_GEN1 = 2'h0,
      PCR_GEN2 = 2'h1,
      PCR_GEN3 = 2'h2,
      PCR_GEN4 = 2'h3
   } pcr_gen_type;

   // reset sequencer states, one-hot
   typedef enum logic [4:0] {
      PCR_RUN        = 5'h01,
      PCR_COLD_ENTRY = 5'h02,
      PCR_COLD_EXIT  = 5'h04,
      PCR_WARM_ENTRY = 5'h08,
      PCR_WARM_EXIT  = 5'h10
   } pcr_state_type;

   // whole state of the controller
   typedef struct packed {
      pcr_state_type   state;
      logic [15:0]     cnt;
      logic            cold_rdy;
      logic            warm_rdy;
      logic            core_rst;
      logic            sticky_rst;
      logic            st_rst;
      logic            sb_rst;
      logic            mm_rst;
      logic [2:0][7:0] mon;
      logic [2:0]      dead;
      pcr_gen_type     gen;
      logic [10:0]     core_mhz;
      logic [9:0]      app_mhz;
   } pcr_ctrl_state_type;

endpackage

/* src/pcr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none

module pcr_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   // raw pins
   input  wire logic [WIDTH-1:0] din,
   // filtered outputs
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);

   // all state of the synchroniser
   typedef struct packed {
      logic [WIDTH-1:0] s1;   // first stage, read by s2 only
      logic [WIDTH-1:0] s2;   // second stage
      logic [WIDTH-1:0] s3;   // third stage
      logic [WIDTH-1:0] lvl;  // accepted level
      logic [WIDTH-1:0] rise; // one-cycle rise of lvl
   } pcr_sync_state_type;

   pcr_sync_state_type st;       // registered state
   pcr_sync_state_type next_st;  // next state

   // shift chain; a change counts once stages two and three agree
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s2[i];
         end
      end
      next_st.rise = next_st.lvl & ~st.lvl;
   end

   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.lvl;
   assign rise  = st.rise;

endmodule

`default_nettype wire

/* src/pcr_reset_ctrl.sv */
// clock and reset sequencing controller of the protocol subsystem
`timescale 1ns/1ps
`default_nettype none

module pcr_reset_ctrl
   import pcr_pkg::*;
(
   // system clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // configured link generation, same clock domain
   input  wire logic [1:0]  link_gen_cfg,
   // reset requests from the application sequencer
   input  wire logic        cold_rst_req,
   input  wire logic        warm_rst_req,
   input  wire logic        stream_bus_rst_req,
   input  wire logic        sideband_bus_rst_req,
   input  wire logic        memmap_bus_rst_req,
   // domain clocks supplied by the application
   input  wire logic        stream_path_clock,
   input  wire logic        sideband_clock,
   input  wire logic        memmap_clock,
   // handshake answers
   output logic             cold_rst_rdy,
   output logic             warm_rst_rdy,
   // internal reset domains, active high
   output logic             core_rst,
   output logic             sticky_rst,
   output logic             stream_if_rst,
   output logic             sideband_if_rst,
   output logic             memmap_if_rst,
   // domain sample strobes
   output logic             stream_sample,
   output logic             sideband_sample,
   output logic             memmap_sample,
   // clock status and frequency report
   output logic [2:0]       clock_stopped,
   output logic [10:0]      core_clk_mhz,
   output logic [9:0]       app_clk_mhz
);

   `include "pcr_consts.svh"

   // synchroniser outputs
   logic [`PCR_SYNC_W-1:0] sync_level;  // filtered levels
   logic [`PCR_SYNC_W-1:0] sync_rise;   // rise pulses

   // decoded inputs
   logic       cold_req;    // synchronised cold request
   logic       warm_req;    // synchronised warm request
   logic [2:0] bus_req;     // stream, sideband, memmap bus requests
   logic [2:0] dom_edge;    // rise of each domain clock
   logic       ip_active;   // an IP reset is in progress

   pcr_ctrl_state_type st;       // registered state
   pcr_ctrl_state_type next_st;  // next state

   // every request pin and foreign-domain clock goes through one synchroniser bank
   pcr_pin_sync #(
      .WIDTH (`PCR_SYNC_W)
   ) u_sync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .din     ({memmap_clock, sideband_clock, stream_path_clock,
                 memmap_bus_rst_req, sideband_bus_rst_req, stream_bus_rst_req,
                 warm_rst_req, cold_rst_req}),
      .level   (sync_level),
      .rise    (sync_rise)
   );

   // unpack the synchroniser bank
   assign cold_req   = sync_level[`PCR_IDX_COLD_REQ];
   assign warm_req   = sync_level[`PCR_IDX_WARM_REQ];
   assign bus_req[0] = sync_level[`PCR_IDX_ST_REQ];
   assign bus_req[1] = sync_level[`PCR_IDX_SB_REQ];
   assign bus_req[2] = sync_level[`PCR_IDX_MM_REQ];
   assign dom_edge[0] = sync_rise[`PCR_IDX_ST_CLK];
   assign dom_edge[1] = sync_rise[`PCR_IDX_SB_CLK];
   assign dom_edge[2] = sync_rise[`PCR_IDX_MM_CLK];
   assign ip_active  = (st.state != PCR_RUN);

   // next-state logic of the whole controller
   always_comb begin
      next_st = st;

      // sequencer
      case (st.state)
         // normal operation: cold wins over warm
         PCR_RUN: begin
            next_st.cnt = '0;
            if (cold_req) begin
               next_st.state      = PCR_COLD_ENTRY;
               next_st.core_rst   = 1'b1;
               next_st.sticky_rst = 1'b1;
            end else if (warm_req) begin
               next_st.state    = PCR_WARM_ENTRY;
               next_st.core_rst = 1'b1;
            end
         end
         // cold entry: hold resets, then answer ready
         PCR_COLD_ENTRY: begin
            next_st.core_rst   = 1'b1;
            next_st.sticky_rst = 1'b1;
            next_st.gen        = pcr_gen_type'(link_gen_cfg);
            if (!st.cold_rdy) begin
               if (st.cnt == 16'(`PCR_ENTRY_CYC - 1)) begin
                  next_st.cold_rdy = 1'b1;
                  next_st.cnt      = '0;
               end else begin
                  next_st.cnt = st.cnt + 16'h0001;
               end
            end else if (!cold_req) begin
               // request dropped: start the graceful exit
               next_st.state = PCR_COLD_EXIT;
               next_st.cnt   = '0;
            end
         end
         // cold exit: ready stays up until the core is released
         PCR_COLD_EXIT: begin
            next_st.gen = pcr_gen_type'(link_gen_cfg);
            if (cold_req) begin
               // re-request during exit restarts the entry
               next_st.state    = PCR_COLD_ENTRY;
               next_st.cold_rdy = 1'b0;
               next_st.cnt      = '0;
            end else if (st.cnt == 16'(`PCR_EXIT_CYC - 1)) begin
               next_st.state      = PCR_RUN;
               next_st.core_rst   = 1'b0;
               next_st.sticky_rst = 1'b0;
               next_st.cold_rdy   = 1'b0;
               next_st.cnt        = '0;
            end else begin
               next_st.cnt = st.cnt + 16'h0001;
            end
         end
         // warm entry: sticky registers are left alone
         PCR_WARM_ENTRY: begin
            next_st.core_rst = 1'b1;
            if (cold_req) begin
               next_st.state      = PCR_COLD_ENTRY;
               next_st.sticky_rst = 1'b1;
               next_st.warm_rdy   = 1'b0;
               next_st.cnt        = '0;
            end else if (!st.warm_rdy) begin
               if (st.cnt == 16'(`PCR_ENTRY_CYC - 1)) begin
                  next_st.warm_rdy = 1'b1;
                  next_st.cnt      = '0;
               end else begin
                  next_st.cnt = st.cnt + 16'h0001;
               end
            end else if (!warm_req) begin
               next_st.state = PCR_WARM_EXIT;
               next_st.cnt   = '0;
            end
         end
         // warm exit: back to run, ready for another warm reset
         PCR_WARM_EXIT: begin
            if (cold_req) begin
               next_st.state      = PCR_COLD_ENTRY;
               next_st.sticky_rst = 1'b1;
               next_st.warm_rdy   = 1'b0;
               next_st.cnt        = '0;
            end else if (warm_req) begin
               next_st.state    = PCR_WARM_ENTRY;
               next_st.warm_rdy = 1'b0;
               next_st.cnt      = '0;
            end else if (st.cnt == 16'(`PCR_EXIT_CYC - 1)) begin
               next_st.state    = PCR_RUN;
               next_st.core_rst = 1'b0;
               next_st.warm_rdy = 1'b0;
               next_st.cnt      = '0;
            end else begin
               next_st.cnt = st.cnt + 16'h0001;
            end
         end
         // illegal code: fall back to a full cold exit
         default: begin
            next_st.state      = PCR_COLD_EXIT;
            next_st.core_rst   = 1'b1;
            next_st.sticky_rst = 1'b1;
            next_st.cold_rdy   = 1'b0;
            next_st.warm_rdy   = 1'b0;
            next_st.cnt        = '0;
         end
      endcase

      // bus resets assert on the same edge as the core reset, even when the
      // sequencer forgot its bus requests; a release waits for both the end
      // of the handshake and a domain clock rise, so the interface leaves
      // reset aligned to its own clock
      if (bus_req[0] || ip_active || next_st.core_rst) begin
         next_st.st_rst = 1'b1;
      end else if (dom_edge[0]) begin
         next_st.st_rst = 1'b0;
      end
      if (bus_req[1] || ip_active || next_st.core_rst) begin
         next_st.sb_rst = 1'b1;
      end else if (dom_edge[1]) begin
         next_st.sb_rst = 1'b0;
      end
      if (bus_req[2] || ip_active || next_st.core_rst) begin
         next_st.mm_rst = 1'b1;
      end else if (dom_edge[2]) begin
         next_st.mm_rst = 1'b0;
      end

      // clock watchdogs: a stopped clock would freeze its bus reset
      for (int d = 0; d < 3; d++) begin
         if (dom_edge[d]) begin
            next_st.mon[d]  = '0;
            next_st.dead[d] = 1'b0;
         end else if (st.mon[d] == 8'(`PCR_MON_CYC - 1)) begin
            next_st.dead[d] = 1'b1;
         end else begin
            next_st.mon[d] = st.mon[d] + 8'h01;
         end
      end

      // frequency report from the latched generation
      case (st.gen)
         PCR_GEN4: begin
            next_st.core_mhz = `PCR_CORE_MHZ_GEN4;
            next_st.app_mhz  = `PCR_APP_MHZ_GEN4;
         end
         PCR_GEN3: begin
            next_st.core_mhz = `PCR_CORE_MHZ_GEN3;
            next_st.app_mhz  = `PCR_APP_MHZ_GEN3;
         end
         // down-trained links: app clock keeps the configured rate
         PCR_GEN2: begin
            next_st.core_mhz = `PCR_CORE_MHZ_GEN2;
            next_st.app_mhz  = `PCR_APP_MHZ_GEN3;
         end
         default: begin
            next_st.core_mhz = `PCR_CORE_MHZ_GEN1;
            next_st.app_mhz  = `PCR_APP_MHZ_GEN3;
         end
      endcase
   end

   // state register; reset enters the cold exit with everything held
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st            <= '0;
         st.state      <= PCR_COLD_EXIT;
         st.core_rst   <= 1'b1;
         st.sticky_rst <= 1'b1;
         st.st_rst     <= 1'b1;
         st.sb_rst     <= 1'b1;
         st.mm_rst     <= 1'b1;
         st.gen        <= PCR_GEN4;
         st.core_mhz   <= `PCR_CORE_MHZ_GEN4;
         st.app_mhz    <= `PCR_APP_MHZ_GEN4;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign cold_rst_rdy    = st.cold_rdy;
   assign warm_rst_rdy    = st.warm_rdy;
   assign core_rst        = st.core_rst;
   assign sticky_rst      = st.sticky_rst;
   assign stream_if_rst   = st.st_rst;
   assign sideband_if_rst = st.sb_rst;
   assign memmap_if_rst   = st.mm_rst;
   assign clock_stopped   = st.dead;
   assign core_clk_mhz    = st.core_mhz;
   assign app_clk_mhz     = st.app_mhz;

   // sample strobes are the synchronised clock rises
   assign stream_sample   = dom_edge[0];
   assign sideband_sample = dom_edge[1];
   assign memmap_sample   = dom_edge[2];

endmodule

`default_nettype wire

/* bench/pcr_reset_ctrl_chk.sv */
// port assertions of the clock and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"

module pcr_reset_ctrl_chk (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // generation and cold request
   input  wire logic [1:0]  link_gen_cfg,
   input  wire logic        cold_rst_req,
   // handshake and reset outputs
   input  wire logic        cold_rst_rdy,
   input  wire logic        warm_rst_rdy,
   input  wire logic        core_rst,
   input  wire logic        sticky_rst,
   input  wire logic        stream_if_rst,
   input  wire logic        sideband_if_rst,
   input  wire logic        memmap_if_rst,
   // strobes and frequency report
   input  wire logic        stream_sample,
   input  wire logic        sideband_sample,
   input  wire logic        memmap_sample,
   input  wire logic [10:0] core_clk_mhz,
   input  wire logic [9:0]  app_clk_mhz
);
   // frequencies due for the configured generation
   wire logic [10:0] exp_core = (link_gen_cfg == 2'h3) ? `PCR_CORE_MHZ_GEN4 :
                                (link_gen_cfg == 2'h2) ? `PCR_CORE_MHZ_GEN3 :
                                (link_gen_cfg == 2'h1) ? `PCR_CORE_MHZ_GEN2 : `PCR_CORE_MHZ_GEN1;
   wire logic [9:0]  exp_app  = (link_gen_cfg == 2'h3) ? `PCR_APP_MHZ_GEN4 : `PCR_APP_MHZ_GEN3;

   // one clock domain only
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_core_mhz: assert property ($fell(sticky_rst) |-> core_clk_mhz == exp_core)
      else $error("core clock report wrong after cold exit");
   a_app_mhz: assert property ($fell(sticky_rst) |-> app_clk_mhz == exp_app)
      else $error("application clock report wrong after cold exit");
   a_stream_pulse_gap: assert property (stream_sample |=> !stream_sample [*3])
      else $error("stream strobe longer than one rise");
   a_stream_release: assert property ($fell(stream_if_rst) |-> $past(stream_sample) && !$past(core_rst))
      else $error("stream reset freed off its clock");
   a_side_release: assert property ($fell(sideband_if_rst) |-> $past(sideband_sample) && !$past(core_rst))
      else $error("sideband reset freed off its clock");
   a_mm_release: assert property ($fell(memmap_if_rst) |-> $past(memmap_sample) && !$past(core_rst))
      else $error("memmap reset freed off its clock");
   a_ip_covers_bus: assert property (core_rst |-> stream_if_rst && sideband_if_rst && memmap_if_rst)
      else $error("bus reset low while core held");
   a_sticky_with_core: assert property (sticky_rst |-> core_rst)
      else $error("sticky reset without core reset");
   a_cold_ready: assert property ($rose(sticky_rst) |-> ##13 $rose(cold_rst_rdy))
      else $error("cold ready not on the entry count");
   a_cold_exit: assert property ($fell(cold_rst_rdy) |-> $fell(sticky_rst) && !$past(cold_rst_req, 125))
      else $error("cold ready dropped early or alone");
   a_rdy_holds: assert property (cold_rst_rdy && cold_rst_req |=> cold_rst_rdy)
      else $error("cold ready lost while request held");
   a_warm_sticky: assert property (warm_rst_rdy |-> !sticky_rst && core_rst)
      else $error("warm reset touched sticky state");
endmodule

bind pcr_reset_ctrl pcr_reset_ctrl_chk pcr_reset_ctrl_chk_i (.*);
`default_nettype wire

/* bench/pcr_app_seq.sv */
// application reset sequencer and domain clock model
`timescale 1ns/1ps
`default_nettype none

module pcr_app_seq (
   // system clock and scenario command
   input  wire logic  sys_clk,
   input  wire logic  halt,
   // handshake answers
   input  wire logic  cold_rst_rdy,
   input  wire logic  warm_rst_rdy,
   // requests and domain clocks
   output logic       cold_rst_req,
   output logic       warm_rst_req,
   output logic [2:0] bus_req,
   output logic [2:0] dom_clk
);
   // free clocks, scaled slow so the pin sampler sees each level
   initial begin
      cold_rst_req = 1'b0;
      warm_rst_req = 1'b0;
      bus_req = 3'h0;
      dom_clk = 3'h0;
      // offset keeps domain clock edges off the system clock edges
      #1;
      fork
         forever #36 if (!halt) dom_clk[0] = ~dom_clk[0];
         forever #44 if (!halt) dom_clk[1] = ~dom_clk[1];
         forever #52 if (!halt) dom_clk[2] = ~dom_clk[2];
      join
   end

   // bus request changes on its own domain's rising edge
   task automatic bus_set(input int i, input logic v);
      wait (dom_clk[i] === 1'b0);
      wait (dom_clk[i] === 1'b1);
      bus_req[i] <= v;
   endtask

   // warm and bus requests, plus cold for a cold entry, raised together, then wait for ready
   task automatic ip_enter(input logic cold, output int t);
      t = 0;
      @(posedge sys_clk);
      cold_rst_req <= cold;
      warm_rst_req <= 1'b1;
      bus_req <= 3'h7;
      while ((cold ? cold_rst_rdy : warm_rst_rdy) !== 1'b1 && t < 300) begin
         @(posedge sys_clk);
         t++;
      end
   endtask

   // drop request, wait ready low, then free buses
   task automatic ip_leave(input logic cold, output int t);
      t = 0;
      cold_rst_req <= 1'b0;
      warm_rst_req <= 1'b0;
      while ((cold ? cold_rst_rdy : warm_rst_rdy) !== 1'b0 && t < 300) begin
         @(posedge sys_clk);
         t++;
      end
      for (int i = 0; i < 3; i++) bus_set(i, 1'b0);
   endtask
endmodule
`default_nettype wire

/* bench/pcie_subsystem_clock_reset_tb.sv */
// self-checking bench of the clock and reset controller
`timescale 1ns/1ps
`default_nettype none

module pcie_subsystem_clock_reset_tb;
   logic             sys_clk;       // 125 MHz
   logic             arst_n;        // async reset, active low
   logic             halt;          // stops domain clocks
   logic [1:0]       link_gen_cfg;  // configured generation
   wire logic        cold_rst_req;  // partner requests
   wire logic        warm_rst_req;
   wire logic [2:0]  bus_req;
   wire logic [2:0]  dom_clk;       // stream, sideband, memmap
   wire logic        cold_rst_rdy;  // design answers
   wire logic        warm_rst_rdy;
   wire logic        core_rst;
   wire logic        sticky_rst;
   wire logic [2:0]  if_rst;
   wire logic [2:0]  sample;
   wire logic [2:0]  clock_stopped;
   wire logic [10:0] core_clk_mhz;
   wire logic [9:0]  app_clk_mhz;
   int               num_errors;
   int               cmp_count;
   int               cycles = 0;
   int               t;

   pcr_reset_ctrl pcr_reset_ctrl_i (
      .sys_clk(sys_clk), .arst_n(arst_n), .link_gen_cfg(link_gen_cfg),
      .cold_rst_req(cold_rst_req), .warm_rst_req(warm_rst_req),
      .stream_bus_rst_req(bus_req[0]), .sideband_bus_rst_req(bus_req[1]),
      .memmap_bus_rst_req(bus_req[2]), .stream_path_clock(dom_clk[0]),
      .sideband_clock(dom_clk[1]), .memmap_clock(dom_clk[2]),
      .cold_rst_rdy(cold_rst_rdy), .warm_rst_rdy(warm_rst_rdy),
      .core_rst(core_rst), .sticky_rst(sticky_rst), .stream_if_rst(if_rst[0]),
      .sideband_if_rst(if_rst[1]), .memmap_if_rst(if_rst[2]),
      .stream_sample(sample[0]), .sideband_sample(sample[1]),
      .memmap_sample(sample[2]), .clock_stopped(clock_stopped),
      .core_clk_mhz(core_clk_mhz), .app_clk_mhz(app_clk_mhz));

   pcr_app_seq pcr_app_seq_i (
      .sys_clk(sys_clk), .halt(halt), .cold_rst_rdy(cold_rst_rdy),
      .warm_rst_rdy(warm_rst_rdy), .cold_rst_req(cold_rst_req),
      .warm_rst_req(warm_rst_req), .bus_req(bus_req), .dom_clk(dom_clk));

   // compare and count
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // verdict and stop
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // reset values, then power-up acts as a cold exit
   task automatic s_power();
      check("rst_outs", {cold_rst_rdy, warm_rst_rdy, sticky_rst, core_rst, if_rst}, 11'h01f);
      arst_n <= 1'b1;
      repeat (140) @(posedge sys_clk);
      check("up_core_mhz", core_clk_mhz, 11'h3e8);
      check("up_app_mhz", 11'(app_clk_mhz), 11'h1f4);
      check("up_ip_rst", {sticky_rst, core_rst}, 11'h000);
      repeat (30) @(posedge sys_clk);
      check("up_bus_rst", if_rst, 11'h000);
   endtask

   // cold cycle under every generation
   task automatic s_gens();
      logic [10:0] cm [4];
      cm = '{11'h07d, 11'h0fa, 11'h1f4, 11'h3e8};
      for (int g = 0; g < 4; g++) begin
         @(posedge sys_clk);
         link_gen_cfg <= 2'(g);
         pcr_app_seq_i.ip_enter(1'b1, t);
         check("cold_entry", 11'(t >= 17 && t <= 20), 11'h001);
         check("cold_held", {sticky_rst, core_rst, if_rst}, 11'h01f);
         pcr_app_seq_i.ip_leave(1'b1, t);
         check("cold_exit", 11'(t >= 127 && t <= 132), 11'h001);
         check("core_mhz", core_clk_mhz, cm[g]);
         check("app_mhz", 11'(app_clk_mhz), (g == 3) ? 11'h1f4 : 11'h0fa);
      end
   endtask

   // warm twice with no cold between; sticky left alone
   task automatic s_warm();
      repeat (2) begin
         pcr_app_seq_i.ip_enter(1'b0, t);
         check("warm_entry", 11'(t >= 17 && t <= 20), 11'h001);
         check("warm_held", {sticky_rst, core_rst, if_rst}, 11'h00f);
         pcr_app_seq_i.ip_leave(1'b0, t);
         check("warm_exit", 11'(t >= 127 && t <= 132), 11'h001);
      end
   endtask

   // cold request taking over a warm reset that already has ready
   task automatic s_preempt();
      pcr_app_seq_i.ip_enter(1'b0, t);
      check("pre_warm_entry", 11'(t >= 17 && t <= 20), 11'h001);
      pcr_app_seq_i.ip_enter(1'b1, t);
      check("pre_cold_entry", 11'(t >= 17 && t <= 20), 11'h001);
      check("pre_warm_rdy", 11'(warm_rst_rdy), 11'h000);
      check("pre_held", {sticky_rst, core_rst, if_rst}, 11'h01f);
      pcr_app_seq_i.ip_leave(1'b1, t);
      check("pre_exit", 11'(t >= 127 && t <= 132), 11'h001);
      check("pre_ip_rst", {sticky_rst, core_rst}, 11'h000);
   endtask

   // each bus reset alone hits only its own domain
   task automatic s_bus();
      for (int i = 0; i < 3; i++) begin
         repeat (30) @(posedge sys_clk);
         pcr_app_seq_i.bus_set(i, 1'b1);
         repeat (8) @(posedge sys_clk);
         check("bus_only", {core_rst, if_rst}, 11'(1 << i));
         pcr_app_seq_i.bus_set(i, 1'b0);
         repeat (30) @(posedge sys_clk);
         check("bus_free", if_rst, 11'h000);
      end
   endtask

   // one strobe per domain clock rise, window edges may split one
   task automatic s_sample();
      int np [3];
      int ns [3];
      logic [2:0] prev;
      np = '{0, 0, 0};
      ns = '{0, 0, 0};
      prev = dom_clk;
      repeat (200) begin
         @(posedge sys_clk);
         for (int i = 0; i < 3; i++) begin
            np[i] += int'(dom_clk[i] & ~prev[i]);
            ns[i] += int'(sample[i]);
         end
         prev = dom_clk;
      end
      for (int i = 0; i < 3; i++)
         check("strobes", 11'(ns[i] + 1 >= np[i] && ns[i] <= np[i] + 1), 11'h001);
   endtask

   // stopped clocks are flagged, then cleared on resume
   task automatic s_stop();
      halt <= 1'b1;
      repeat (90) @(posedge sys_clk);
      check("stopped", clock_stopped, 11'h007);
      halt <= 1'b0;
      repeat (40) @(posedge sys_clk);
      check("running", clock_stopped, 11'h000);
   endtask

   // system clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         num_errors++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      num_errors = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      halt = 1'b0;
      link_gen_cfg = 2'h3;
      repeat (12) @(posedge sys_clk);
      s_power();
      s_gens();
      s_warm();
      s_preempt();
      s_bus();
      s_sample();
      s_stop();
      end_of_test();
   end
endmodule
`default_nettype wire
